/* rtl/beq_consts.svh */
// offsets, field positions, reset values and timing counts of the bus event qualifier
`ifndef BEQ_CONSTS_SVH
`define BEQ_CONSTS_SVH

// ****************************************
// register byte addresses
// ****************************************
`define BEQ_OFF_SEL_FIRST 8'h00
`define BEQ_OFF_SEL_SECOND 8'h04
`define BEQ_OFF_CONFIG 8'h08
`define BEQ_OFF_COUNT_FIRST 8'h0C
`define BEQ_OFF_COUNT_SECOND 8'h10

// ****************************************
// select register fields
// ****************************************
`define BEQ_EVSEL_MSB 31
`define BEQ_EVSEL_LSB 25
`define BEQ_MASK_MSB 24
`define BEQ_MASK_LSB 9
`define BEQ_MODEL_MSB 3
`define BEQ_EVSEL_DATA_ACT 7'h17
`define BEQ_EVSEL_QUEUE_ALLOC 7'h03
`define BEQ_MODEL_NEW_MIN 4'h2
`define BEQ_SEL_RESET 32'h0000_0000

// ****************************************
// queue allocation mask bits
// ****************************************
`define BEQ_QM_REQ_MSB 4
`define BEQ_QM_ALL_READ 5
`define BEQ_QM_ALL_WRITE 6
`define BEQ_QM_MEM_LSB 7
`define BEQ_QM_MEM_MSB 11
`define BEQ_QM_OWN 13
`define BEQ_QM_OTHER 14

// ****************************************
// data activity mask bits and timing
// ****************************************
`define BEQ_DM_DRV 0
`define BEQ_DM_OWN 1
`define BEQ_DM_OTHER 2
`define BEQ_DM_RSV_DRV 3
`define BEQ_LINE_BYTES 64
`define BEQ_CHUNK_BYTES 8
`define BEQ_DATA_READY_CONDITION_PARTIAL_CLKS 3'h2
`define BEQ_DATA_READY_CONDITION_FULL_CLKS 3'h4

`endif

/* rtl/beq_data_ready_condition_gen.sv */
// data-ready condition stretcher: two clocks partial, four clocks full line
`timescale 1ns/10ps
`default_nettype none
`include "beq_consts.svh"
module beq_data_ready_condition_gen
  import beq_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // data phase start
  input wire logic start,
  input wire logic full,
  input wire logic [1:0] cls,
  // one-hot condition drv, own, other
  output logic [2:0] cond
);

  typedef struct packed {
    logic [2:0] left;
    logic [1:0] cls;
    logic [2:0] cond;
  } beq_data_ready_condition_state_s;

  beq_data_ready_condition_state_s st_r;
  beq_data_ready_condition_state_s st_nxt;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    st_nxt = st_r;
    if (start) begin
      // a new phase restarts the stretch, no overlap on a real bus
      st_nxt.left = full ? `BEQ_DATA_READY_CONDITION_FULL_CLKS : `BEQ_DATA_READY_CONDITION_PARTIAL_CLKS;
      st_nxt.cls = cls;
    end else if (st_r.left != 3'h0) begin
      st_nxt.left = st_r.left - 3'h1;
    end
    st_nxt.cond = 3'h0;
    if (st_nxt.left != 3'h0) begin
      case (beq_cls_e'(st_nxt.cls))
        BEQ_CLS_DRV: st_nxt.cond = 3'b001;
        BEQ_CLS_OWN: st_nxt.cond = 3'b010;
        BEQ_CLS_OTHER: st_nxt.cond = 3'b100;
        default: st_nxt.cond = 3'b000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign cond = st_r.cond;

endmodule
`default_nettype wire

/* rtl/beq_pkg.sv */
// types shared by the bus event qualifier modules
package beq_pkg;

  // data phase owner class
  typedef enum logic [1:0] {
    BEQ_CLS_DRV,
    BEQ_CLS_OWN,
    BEQ_CLS_OTHER,
    BEQ_CLS_NONE
  } beq_cls_e;

  // bus pins as seen by the qualifier
  typedef struct packed {
    logic alloc_valid;
    logic [4:0] req_type;
    logic is_read;
    logic is_write;
    logic [4:0] mem_type;
    logic own_agent;
    logic [1:0] priv_level;
    logic dphase_start;
    logic dphase_full;
    logic [1:0] dphase_class;
    logic rsv_self_drive;
  } beq_bus_s;

  // one event selection register
  typedef struct packed {
    logic [6:0] evsel;
    logic [15:0] mask;
  } beq_sel_s;

endpackage

/* rtl/beq_top.sv */
// bus event qualifier: apb registers, queue allocation and data activity events
`timescale 1ns/10ps
`default_nettype none
`include "beq_consts.svh"
module beq_top
  import beq_pkg::*;
#(
  parameter logic [3:0] MODEL_ID = 4'h2,
  parameter int CNT_W = 16
)
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // system bus observation pins
  input wire beq_bus_s bus_pins,
  // increment requests to counters 0..3
  output logic [3:0] cnt_inc
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    beq_sel_s [1:0] sel;
    logic [3:0] model;
    logic [1:0][CNT_W-1:0] count;
    beq_bus_s sync1;
    beq_bus_s sync2;
    logic start_d;
    logic [3:0] inc;
  } beq_state_s;

  beq_state_s st_r;
  beq_state_s st_nxt;

  logic [2:0] data_ready_condition_cond;
  logic start_pulse;
  logic [1:0] hit;

  // ****************************************
  // decode helpers
  // ****************************************
  function automatic logic [2:0] reg_index(input logic [7:0] addr);
    case (addr)
      `BEQ_OFF_SEL_FIRST: reg_index = 3'h0;
      `BEQ_OFF_SEL_SECOND: reg_index = 3'h1;
      `BEQ_OFF_CONFIG: reg_index = 3'h2;
      `BEQ_OFF_COUNT_FIRST: reg_index = 3'h3;
      `BEQ_OFF_COUNT_SECOND: reg_index = 3'h4;
      default: reg_index = 3'h7;
    endcase
  endfunction

  function automatic logic [31:0] sel_word(input beq_sel_s s);
    sel_word = 32'h0000_0000;
    sel_word[`BEQ_EVSEL_MSB:`BEQ_EVSEL_LSB] = s.evsel;
    sel_word[`BEQ_MASK_MSB:`BEQ_MASK_LSB] = s.mask;
  endfunction

  // read mux for every mapped offset; unmapped reads return zero
  function automatic logic [31:0] read_word(
    input logic [2:0] idx,
    input beq_sel_s s0,
    input beq_sel_s s1,
    input logic [3:0] model,
    input logic [CNT_W-1:0] c0,
    input logic [CNT_W-1:0] c1
  );
    case (idx)
      3'h0: read_word = sel_word(s0);
      3'h1: read_word = sel_word(s1);
      3'h2: read_word = {28'h000_0000, model};
      3'h3: read_word = 32'(c0);
      3'h4: read_word = 32'(c1);
      default: read_word = 32'h0000_0000;
    endcase
  endfunction

  // writing a count clears it; a hit in the same cycle still counts
  function automatic logic [CNT_W-1:0] next_count(
    input logic [CNT_W-1:0] cur,
    input logic inc,
    input logic clr
  );
    if (clr) begin
      next_count = CNT_W'(inc);
    end else if (inc) begin
      next_count = cur + CNT_W'(1);
    end else begin
      next_count = cur;
    end
  endfunction

  // ****************************************
  // queue allocation qualifier
  // ****************************************
  function automatic logic q_req(
    input logic [15:0] m,
    input beq_bus_s b
  );
    q_req = (b.req_type == m[`BEQ_QM_REQ_MSB:0]);
  endfunction

  function automatic logic q_dir(
    input logic [15:0] m,
    input beq_bus_s b
  );
    q_dir = (m[`BEQ_QM_ALL_READ] & b.is_read) | (m[`BEQ_QM_ALL_WRITE] & b.is_write);
  endfunction

  function automatic logic q_all_rw(
    input logic [15:0] m
  );
    q_all_rw = m[`BEQ_QM_ALL_READ] | m[`BEQ_QM_ALL_WRITE];
  endfunction

  function automatic logic q_mem(
    input logic [15:0] m,
    input beq_bus_s b
  );
    q_mem = |(m[`BEQ_QM_MEM_MSB:`BEQ_QM_MEM_LSB] & b.mem_type);
  endfunction

  function automatic logic q_src(
    input logic [15:0] m,
    input beq_bus_s b
  );
    q_src = (m[`BEQ_QM_OWN] & b.own_agent) | (m[`BEQ_QM_OTHER] & ~b.own_agent);
  endfunction

  // newer models: every group must agree
  function automatic logic queue_hit_new(
    input logic [15:0] m,
    input beq_bus_s b
  );
    logic mem_t;
    // memory term forced true when all reads or writes chosen
    mem_t = q_mem(m, b) | q_all_rw(m);
    queue_hit_new = q_req(m, b) & q_dir(m, b) & mem_t & q_src(m, b);
  endfunction

  // older models: any of the first groups, then the source
  function automatic logic queue_hit_old(
    input logic [15:0] m,
    input beq_bus_s b
  );
    logic mem_t;
    // memory term dropped when all reads or writes chosen
    mem_t = q_mem(m, b) & ~q_all_rw(m);
    queue_hit_old = (q_req(m, b) | q_dir(m, b) | mem_t) & q_src(m, b);
  endfunction

  function automatic logic queue_hit(
    input logic [15:0] m,
    input beq_bus_s b,
    input logic new_model
  );
    // b.priv_level is never looked at: user and supervisor both count
    queue_hit = 1'b0;
    if (b.alloc_valid) begin
      // one valid cycle is one entry, a line or a chunk alike
      if (new_model) begin
        queue_hit = queue_hit_new(m, b);
      end else begin
        queue_hit = queue_hit_old(m, b);
      end
    end
  endfunction

  // ****************************************
  // data activity qualifier
  // ****************************************
  function automatic logic data_hit(
    input logic [15:0] m,
    input logic [2:0] cond,
    input logic rsv_drv
  );
    logic c_drv;
    logic c_own;
    logic c_oth;
    logic c_rsv;
    c_drv = m[`BEQ_DM_DRV] & cond[0];
    c_own = m[`BEQ_DM_OWN] & cond[1];
    c_oth = m[`BEQ_DM_OTHER] & cond[2];
    c_rsv = m[`BEQ_DM_RSV_DRV] & rsv_drv;
    data_hit = c_drv | c_own | c_oth | c_rsv;
  endfunction

  // ****************************************
  // data-ready stretcher
  // ****************************************
  assign start_pulse = st_r.sync2.dphase_start & ~st_r.start_d;

  beq_data_ready_condition_gen u_data_ready_condition (
    .pclk(pclk),
    .presetn(presetn),
    .start(start_pulse),
    .full(st_r.sync2.dphase_full),
    .cls(st_r.sync2.dphase_class),
    .cond(data_ready_condition_cond)
  );

  // ****************************************
  // per select register event decision
  // ****************************************
  generate
    for (genvar g = 0; g < 2; g++) begin : g_sel
      always_comb begin
        hit[g] = 1'b0;
        case (st_r.sel[g].evsel)
          `BEQ_EVSEL_DATA_ACT: begin
            hit[g] = data_hit(st_r.sel[g].mask, data_ready_condition_cond,
              st_r.sync2.rsv_self_drive);
          end
          `BEQ_EVSEL_QUEUE_ALLOC: begin
            hit[g] = queue_hit(st_r.sel[g].mask, st_r.sync2,
              st_r.model >= `BEQ_MODEL_NEW_MIN);
          end
          default: hit[g] = 1'b0;
        endcase
      end
    end
  endgenerate

  // ****************************************
  // counter pair fan-out
  // ****************************************
  // first select feeds counters 0,1, second feeds 2,3
  logic [3:0] inc_vec;
  generate
    for (genvar k = 0; k < 4; k++) begin : g_inc
      assign inc_vec[k] = hit[k / 2];
    end
  endgenerate

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic [2:0] idx;
    st_nxt = st_r;
    idx = reg_index(paddr);
    // pins pass two flops before any logic sees them
    st_nxt.sync1 = bus_pins;
    st_nxt.sync2 = st_r.sync1;
    st_nxt.start_d = st_r.sync2.dphase_start;
    st_nxt.inc = inc_vec;
    for (int i = 0; i < 2; i++) begin
      st_nxt.count[i] = next_count(st_r.count[i], hit[i],
        psel && penable && st_r.pready && pwrite && (idx == 3'(3 + i)));
    end
    // apb: setup loads the answer, access completes in one cycle
    st_nxt.pready = 1'b0;
    st_nxt.pslverr = 1'b0;
    if (psel && !penable) begin
      st_nxt.pready = 1'b1;
      st_nxt.pslverr = (idx == 3'h7);
      st_nxt.prdata = read_word(idx, st_r.sel[0], st_r.sel[1], st_r.model,
        st_r.count[0], st_r.count[1]);
    end
    if (psel && penable && st_r.pready && pwrite) begin
      case (idx)
        3'h0: begin
          st_nxt.sel[0].evsel = pwdata[`BEQ_EVSEL_MSB:`BEQ_EVSEL_LSB];
          st_nxt.sel[0].mask = pwdata[`BEQ_MASK_MSB:`BEQ_MASK_LSB];
        end
        3'h1: begin
          st_nxt.sel[1].evsel = pwdata[`BEQ_EVSEL_MSB:`BEQ_EVSEL_LSB];
          st_nxt.sel[1].mask = pwdata[`BEQ_MASK_MSB:`BEQ_MASK_LSB];
        end
        3'h2: st_nxt.model = pwdata[`BEQ_MODEL_MSB:0];
        // count clears are handled with the increment above
        default: st_nxt.model = st_r.model;
      endcase
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
      st_r.model <= MODEL_ID;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata = st_r.prdata;
  assign pready = st_r.pready;
  assign pslverr = st_r.pslverr;
  assign cnt_inc = st_r.inc;

endmodule
`default_nettype wire

/* verif/beq_bus_agent.sv */
// model of the other bus agents driving the observed pins
`timescale 1ns/10ps
`default_nettype none
module beq_bus_agent
  import beq_pkg::*;
(
  // clock
  input wire logic pclk,
  // observed pins
  output var beq_bus_s pins
);
  initial pins = '0;
  // one cycle of activity, then released lines show the inverse, except alloc_valid, dphase_start and rsv_self_drive, which drop to zero
  task send(input beq_bus_s v);
    beq_bus_s idle;
    idle = ~v;
    idle.alloc_valid = 1'b0;
    idle.dphase_start = 1'b0;
    idle.rsv_self_drive = 1'b0;
    @(posedge pclk);
    pins <= v;
    @(posedge pclk);
    pins <= idle;
  endtask
endmodule
`default_nettype wire

/* verif/beq_top_sva.sv */
// concurrent checks on the bus event qualifier ports
`timescale 1ns/10ps
`default_nettype none
module beq_top_sva
  import beq_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // bus and counters
  input wire beq_bus_s bus_pins,
  input wire logic [3:0] cnt_inc
);
  // select shadows from apb writes, so no body signal is needed
  logic [31:0] s0_r;
  logic [31:0] s1_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s0_r <= '0;
      s1_r <= '0;
    end else if (psel && penable && pready && pwrite) begin
      if (paddr == 8'h00) s0_r <= pwdata;
      if (paddr == 8'h04) s1_r <= pwdata;
    end
  end
  wire da0 = s0_r[31:25] == 7'h17;
  wire da1 = s1_r[31:25] == 7'h17;
  wire qa0 = s0_r[31:25] == 7'h03;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ****************
  // checks
  // ****************
  sequence dstart(c, f, en); en && $rose(bus_pins.dphase_start) && bus_pins.dphase_class == c && bus_pins.dphase_full == f; endsequence
  sequence burst2(b); !b ##1 b [*2] ##1 !b; endsequence
  sequence burst4(b); !b ##1 b [*4] ##1 !b; endsequence
  sequence one_pulse(b); !b ##1 b ##1 !b; endsequence
  apb_ready_a: assert property (psel && !penable |=> pready)
    else $error("no pready in access cycle");
  unmapped_err_a: assert property (psel && !penable && !pwrite && paddr > 8'h10 |=> pslverr && prdata == 0)
    else $error("unmapped read not refused");
  drv_partial_a: assert property (dstart(2'h0, 1'b0, da0 && s0_r[9]) |-> ##[3:5] burst2(cnt_inc[0]))
    else $error("driven partial data not two pulses");
  drv_full_a: assert property (dstart(2'h0, 1'b1, da0 && s0_r[9]) |-> ##[3:5] burst4(cnt_inc[0]))
    else $error("driven full line data not four pulses");
  own_full_a: assert property (dstart(2'h1, 1'b1, da0 && s0_r[10]) |-> ##[3:5] burst4(cnt_inc[1]))
    else $error("sampled full line data not four pulses");
  other_part_a: assert property (dstart(2'h2, 1'b0, da1 && s1_r[11]) |-> ##[3:5] burst2(cnt_inc[2]))
    else $error("unsampled partial data not two pulses");
  rsv_drive_a: assert property (da0 && s0_r[12] && $rose(bus_pins.rsv_self_drive) |-> ##[1:3] one_pulse(cnt_inc[0]))
    else $error("bus reserve not one pulse");
  alloc_hit_a: assert property (qa0 && $rose(bus_pins.alloc_valid) && bus_pins.req_type == s0_r[13:9] && bus_pins.is_read && s0_r[14] && bus_pins.own_agent && s0_r[22] |-> ##[1:3] one_pulse(cnt_inc[0]))
    else $error("matching allocation not one pulse");
  alloc_src_a: assert property (qa0 && bus_pins.alloc_valid && (bus_pins.own_agent ? !s0_r[22] : !s0_r[23]) |-> ##2 (!cnt_inc[0]) [*3])
    else $error("allocation counted from wrong source");
  sel_gate_a: assert property (cnt_inc[0] |-> da0 || qa0)
    else $error("increment without matching event select");
  inc_pair_a: assert property (cnt_inc[1] == cnt_inc[0] && cnt_inc[3] == cnt_inc[2])
    else $error("counter pair increments differ");
endmodule
bind beq_top beq_top_sva u_beq_top_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .bus_pins(bus_pins), .cnt_inc(cnt_inc));
`default_nettype wire

/* verif/bus_event_qualifier_bench.sv */
// self-checking bench for the bus event qualifier
`timescale 1ns/10ps
`default_nettype none
`include "beq_consts.svh"
module bus_event_qualifier_bench
  import beq_pkg::*;
;
  localparam logic [6:0] DA = `BEQ_EVSEL_DATA_ACT;
  localparam logic [6:0] QA = `BEQ_EVSEL_QUEUE_ALLOC;
  localparam logic [15:0] QM = 16'h20A1;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err;
  logic [3:0] cnt_inc;
  beq_bus_s bus_pins;
  int failures = 0, compares = 0, hits0 = 0, hits2 = 0;
  initial forever #25 pclk = ~pclk;
  beq_top #(.MODEL_ID(4'h2), .CNT_W(16)) u_beq_top (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus_pins(bus_pins),
    .cnt_inc(cnt_inc));
  beq_bus_agent u_beq_bus_agent (.pclk(pclk), .pins(bus_pins));
  // bits 1 and 3 mirror 0 and 2, left to the checker
  always @(posedge pclk) begin
    if (cnt_inc[0] === 1'b1) hits0 <= hits0 + 1;
    if (cnt_inc[2] === 1'b1) hits2 <= hits2 + 1;
  end
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task final_report;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 16) begin
      n++;
      @(posedge pclk);
    end
    if (n == 16) begin
      failures++;
      final_report();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [31:0] sw(input logic [6:0] ev, input logic [15:0] m);
    return {ev, m, 9'h000};
  endfunction
  function automatic beq_bus_s dp(input logic [1:0] c, input logic f);
    return '{dphase_start: 1'b1, dphase_full: f, dphase_class: c, default: '0};
  endfunction
  function automatic beq_bus_s al(input logic [4:0] rq, input logic r, input logic [4:0] mt,
    input logic o, input logic [1:0] pl);
    return '{alloc_valid: 1'b1, req_type: rq, is_read: r, is_write: ~r, mem_type: mt,
      own_agent: o, priv_level: pl, default: '0};
  endfunction
  // program both selects, send one bus event, count increments on 0 and 2
  task scen(input logic [31:0] s0, input logic [31:0] s1, input beq_bus_s v,
    input int e0, input int e2);
    int b0, b2;
    apb(1'b1, 8'h00, s0);
    apb(1'b1, 8'h04, s1);
    b0 = hits0;
    b2 = hits2;
    u_beq_bus_agent.send(v);
    repeat (14) @(posedge pclk);
    check("hits first", 32'(hits0 - b0), 32'(e0));
    check("hits second", 32'(hits2 - b2), 32'(e2));
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h08, 32'h0000_0000);
    check("model reset", rd, 32'h0000_0002);
    check("mapped error", {31'h0000_0000, err}, 32'h0000_0000);
    apb(1'b0, 8'h04, 32'h0000_0000);
    check("select reset", rd, 32'h0000_0000);
    apb(1'b1, 8'h00, 32'hFFFF_FFFF);
    apb(1'b0, 8'h00, 32'h0000_0000);
    check("select fields", rd, 32'hFFFF_FE00);
    apb(1'b0, 8'h20, 32'h0000_0000);
    check("unmapped error", {31'h0000_0000, err}, 32'h0000_0001);
    check("unmapped data", rd, 32'h0000_0000);
    scen(sw(DA, 16'h0001), 32'h0000_0000, dp(2'h0, 1'b0), 2, 0);
    apb(1'b1, 8'h0C, 32'h0000_0000);
    scen(sw(DA, 16'h0001), 32'h0000_0000, dp(2'h0, 1'b1), 4, 0);
    apb(1'b0, 8'h0C, 32'h0000_0000);
    check("count first", rd, 32'h0000_0004);
    scen(sw(DA, 16'h0002), 32'h0000_0000, dp(2'h1, 1'b1), 4, 0);
    scen(sw(DA, 16'h0002), 32'h0000_0000, dp(2'h1, 1'b0), 2, 0);
    apb(1'b1, 8'h10, 32'h0000_0000);
    scen(32'h0000_0000, sw(DA, 16'h0004), dp(2'h2, 1'b0), 0, 2);
    scen(32'h0000_0000, sw(DA, 16'h0004), dp(2'h2, 1'b1), 0, 4);
    apb(1'b0, 8'h10, 32'h0000_0000);
    check("count second", rd, 32'h0000_0006);
    scen(sw(DA, 16'h0001), 32'h0000_0000, dp(2'h1, 1'b1), 0, 0);
    scen(sw(DA, 16'h000B), 32'h0000_0000, dp(2'h3, 1'b1), 0, 0);
    scen(sw(7'h00, 16'h0001), 32'h0000_0000, dp(2'h0, 1'b1), 0, 0);
    scen(sw(DA, 16'h0008), 32'h0000_0000, beq_bus_s'(21'h00_0001), 1, 0);
    scen(sw(QA, QM), 32'h0000_0000, al(5'h01, 1'b1, 5'h01, 1'b1, 2'h0), 1, 0);
    scen(sw(QA, QM), 32'h0000_0000, al(5'h01, 1'b1, 5'h01, 1'b1, 2'h3), 1, 0);
    scen(sw(QA, QM), 32'h0000_0000, al(5'h01, 1'b1, 5'h01, 1'b0, 2'h0), 0, 0);
    scen(sw(QA, QM), 32'h0000_0000, al(5'h02, 1'b1, 5'h01, 1'b1, 2'h0), 0, 0);
    scen(sw(QA, QM), 32'h0000_0000, al(5'h01, 1'b1, 5'h10, 1'b1, 2'h0), 1, 0);
    apb(1'b1, 8'h08, 32'h0000_0001);
    apb(1'b0, 8'h08, 32'h0000_0000);
    check("model set", rd, 32'h0000_0001);
    scen(sw(QA, QM), 32'h0000_0000, al(5'h02, 1'b1, 5'h10, 1'b1, 2'h0), 1, 0);
    scen(sw(QA, QM), 32'h0000_0000, al(5'h02, 1'b0, 5'h01, 1'b1, 2'h0), 0, 0);
    scen(sw(QA, QM), 32'h0000_0000, al(5'h01, 1'b1, 5'h01, 1'b0, 2'h0), 0, 0);
    final_report();
  end
endmodule
`default_nettype wire
